// ---- bmi_reset_boot.sv ----
`include "bmi_cfg.svh"
`default_nettype none
module bmi_reset_boot #(
  parameter int unsigned MODE_BITS = `BMI_MODE_BITS
) (
  input  wire logic                   clk_sys_i,          // Master clock, 10 MHz
  input  wire logic                   rst_n_i,            // Sync reset, active low
  input  wire logic                   supply_good_i,      // Supply stable, pin
  input  wire logic                   power_on_reset_n_i, // Cold reset pin
  input  wire logic                   sys_reset_n_i,      // General reset pin
  input  wire logic                   boot_serial_in_i,   // Mode ROM data
  input  wire logic                   byte_order_sel_i,   // Byte order pin
  output logic                        boot_serial_clk_o,  // Mode ROM clock
  output logic [MODE_BITS-1:0]        mode_word_o,        // Captured mode bits
  output logic                        mode_valid_o,       // Mode bits complete
  output logic                        core_reset_n_o,     // Core out of reset
  output logic                        warm_reset_o,       // Warm reset active
  output logic                        big_endian_o,       // Effective byte order
  output logic [3:0]                  pll_mult_o,         // Pipeline clock factor
  output bmi_pkg::bmi_state_t         state_o             // Sequencer state
);
  import bmi_pkg::*;

  localparam int unsigned CW = (MODE_BITS > 1) ? $clog2(MODE_BITS) : 1;

  function automatic logic [3:0] mult_clamp(input logic [`BMI_MULT_W-1:0] code);
    logic [3:0] m;
    m = 4'({1'b0, code}) + `BMI_MULT_BASE;
    if (m > `BMI_MULT_MAX) begin
      m = `BMI_MULT_MAX;
    end
    return m;
  endfunction : mult_clamp

  // Pin synchronisers: three stages, change taken once stages 2 and 3 agree
  logic [`BMI_PIN_CNT-1:0][2:0] sync_q, sync_d;
  logic [`BMI_PIN_CNT-1:0]      flt_q, flt_d;
  logic [`BMI_PIN_CNT-1:0]      pins;
  logic                         sg, por_n, srst_n, sin, bsel;

  assign pins = {supply_good_i, power_on_reset_n_i, sys_reset_n_i,
                 boot_serial_in_i, byte_order_sel_i};

  always_comb begin
    for (int k = 0; k < `BMI_PIN_CNT; k++) begin
      sync_d[k] = {sync_q[k][1:0], pins[k]};
      flt_d[k]  = (sync_q[k][1] == sync_q[k][2]) ? sync_q[k][2] : flt_q[k];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sync_q <= '0;
      flt_q  <= '0;
    end else begin
      sync_q <= sync_d;
      flt_q  <= flt_d;
    end
  end

  assign sg     = flt_q[4];
  assign por_n  = flt_q[3];
  assign srst_n = flt_q[2];
  assign sin    = flt_q[1];
  assign bsel   = flt_q[0];

  // Free-running divider; ROM clock toggles at mid and end of count
  logic [`BMI_DIV_W-1:0] div_q, div_d;
  logic                  sclk_q, sclk_d;
  logic                  sample;

  always_comb begin
    div_d  = div_q + `BMI_DIV_W'(1);
    sclk_d = div_d[`BMI_DIV_W-1];
    sample = (div_q == `BMI_SAMPLE_CNT);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      div_q  <= '0;
      sclk_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      sclk_q <= sclk_d;
    end
  end

  // Sequencer
  bmi_state_t           state_q, state_d;
  logic [MODE_BITS-1:0] mode_q, mode_d;
  logic [CW-1:0]        bit_q, bit_d;
  logic                 warm_q, warm_d;
  logic                 rel_q, rel_d;
  logic                 endian_q, endian_d;
  logic [3:0]           mult_q, mult_d;

  always_comb begin
    state_d = state_q;
    mode_d  = mode_q;
    bit_d   = bit_q;
    warm_d  = warm_q;
    case (state_q)
      BMI_IDLE: begin
        if (sg) begin
          state_d = BMI_LOAD;
          mode_d  = '0;
          bit_d   = '0;
        end
      end
      BMI_LOAD: begin
        // Sampled at the ROM clock rising edge, data had almost a full period to settle
        if (sample) begin
          mode_d = {sin, mode_q[MODE_BITS-1:1]};
          bit_d  = bit_q + CW'(1);
          if (bit_q == CW'(MODE_BITS - 1)) begin
            state_d = BMI_HOLD;
          end
        end
      end
      BMI_HOLD: begin
        // Release only once both reset pins are clear; mode is complete by now
        if (por_n && srst_n) begin
          state_d = BMI_RUN;
          warm_d  = 1'b0;
        end
      end
      BMI_RUN: begin
        if (!por_n) begin
          state_d = BMI_HOLD;
          warm_d  = 1'b0;
        end else if (!srst_n) begin
          state_d = BMI_HOLD;
          warm_d  = 1'b1;
        end
      end
      default: begin
        state_d = BMI_IDLE;
      end
    endcase
    // Losing supply aborts everything and forces a fresh ROM read
    if (!sg) begin
      state_d = BMI_IDLE;
      warm_d  = 1'b0;
    end
    rel_d    = (state_d == BMI_RUN);
    endian_d = mode_q[`BMI_ENDIAN_BIT] | bsel;
    mult_d   = mult_clamp(mode_q[`BMI_MULT_LSB +: `BMI_MULT_W]);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q  <= BMI_IDLE;
      mode_q   <= '0;
      bit_q    <= '0;
      warm_q   <= 1'b0;
      rel_q    <= 1'b0;
      endian_q <= 1'b0;
      mult_q   <= `BMI_MULT_MIN;
    end else begin
      state_q  <= state_d;
      mode_q   <= mode_d;
      bit_q    <= bit_d;
      warm_q   <= warm_d;
      rel_q    <= rel_d;
      endian_q <= endian_d;
      mult_q   <= mult_d;
    end
  end

  assign boot_serial_clk_o = sclk_q;
  assign mode_word_o       = mode_q;
  assign mode_valid_o      = (state_q == BMI_HOLD) || (state_q == BMI_RUN);
  assign core_reset_n_o    = rel_q;
  assign warm_reset_o      = warm_q;
  assign big_endian_o      = endian_q;
  assign pll_mult_o        = mult_q;
  assign state_o           = state_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  load_start_a: assert property (
    (state_q == BMI_IDLE) && sg |=> (state_q == BMI_LOAD) && (bit_q == '0))
    else $error("ROM read did not start on supply good");

  sclk_period_a: assert property (
    $rose(boot_serial_clk_o) |-> ##256 $rose(boot_serial_clk_o))
    else $error("Mode clock period is not 256 cycles");

  sclk_high_a: assert property (
    $rose(boot_serial_clk_o) |-> boot_serial_clk_o [*8])
    else $error("Mode clock high phase too short");

  bit_step_a: assert property (
    (state_q == BMI_LOAD) && sg && !sample |=> $stable(bit_q) && $stable(mode_q))
    else $error("Mode bit taken off the sample point");

  endian_pin_a: assert property (
    mode_valid_o && !mode_word_o[`BMI_ENDIAN_BIT] && $stable(mode_word_o)
      |=> big_endian_o == $past(bsel))
    else $error("Byte order not taken from pin");

  mult_range_a: assert property (
    (pll_mult_o >= `BMI_MULT_MIN) && (pll_mult_o <= `BMI_MULT_MAX))
    else $error("Clock multiplier out of range");

  warm_entry_a: assert property (
    (state_q == BMI_RUN) && sg && por_n && !srst_n
      |=> warm_reset_o && !core_reset_n_o && (state_q == BMI_HOLD))
    else $error("Warm reset not entered");

  cold_entry_a: assert property (
    (state_q == BMI_RUN) && sg && !por_n |=> !warm_reset_o && !core_reset_n_o)
    else $error("Cold reset mistaken for warm");

  release_a: assert property (
    core_reset_n_o |-> mode_valid_o && $past(por_n) && $past(srst_n))
    else $error("Core released without complete mode or with reset held");
endmodule : bmi_reset_boot
`default_nettype wire

// ---- bmi_cfg.svh ----
`ifndef BMI_CFG_SVH
`define BMI_CFG_SVH

`define BMI_CLK_HZ       10000000
`define BMI_DIV_RATIO    256
`define BMI_DIV_W        8
`define BMI_SAMPLE_CNT   8'h7F
`define BMI_MODE_BITS    64
`define BMI_ENDIAN_BIT   8
`define BMI_MULT_LSB     5
`define BMI_MULT_W       3
`define BMI_MULT_BASE    4'h2
`define BMI_MULT_MIN     4'h2
`define BMI_MULT_MAX     4'h8
`define BMI_SPEED_BIT_A  20
`define BMI_SPEED_BIT_B  33
`define BMI_PIN_CNT      5

`endif

// ---- bmi_pkg.sv ----
`default_nettype none
package bmi_pkg;
  typedef enum logic [3:0] {
    BMI_IDLE = 4'h1,
    BMI_LOAD = 4'h2,
    BMI_HOLD = 4'h4,
    BMI_RUN  = 4'h8
  } bmi_state_t;
endpackage : bmi_pkg
`default_nettype wire

// ---- bmi_board_model.sv ----
`default_nettype none
module bmi_board_model #(
  parameter int MODE_BITS = 40
) (
  input  wire logic                 clk_sys_i, // Master clock
  input  wire logic                 sg_i,      // Supply good
  input  wire logic                 sclk_i,    // Mode ROM clock
  input  wire logic                 cold_i,    // Cold reset request
  input  wire logic                 warm_i,    // Warm reset request
  input  wire logic [MODE_BITS-1:0] word_i,    // ROM content
  output logic                      por_n_o,   // Cold reset pin
  output logic                      rst_n_o,   // General reset pin
  output logic                      data_o     // Mode ROM data
);
  timeunit 1ns;
  timeprecision 1ns;
  int   idx    = 0;
  logic sclk_q = 1'b0;
  logic por_q  = 1'b0;
  logic rst_q  = 1'b0;
  // Pins move only on the clock edge, never mid-cycle
  always @(posedge clk_sys_i) begin
    por_q <= sg_i && !cold_i;
    rst_q <= sg_i && !cold_i && !warm_i;
    sclk_q <= sclk_i;
    if (!sg_i)
      idx <= 0;
    else if (sclk_i && !sclk_q)
      idx <= idx + 1;
  end
  // One driver per pin; the registers start asserted
  assign por_n_o = por_q;
  assign rst_n_o = rst_q;
  // Past the last bit the line carries the inverse, not a held value
  assign data_o = (idx < MODE_BITS) ? word_i[idx] : ~word_i[MODE_BITS-1];
endmodule : bmi_board_model
`default_nettype wire

// ---- bmi_reset_boot_tb_top.sv ----
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: %0h, expected %0h", $time, (a), (e)); end end
module bmi_reset_boot_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bmi_pkg::*;
  localparam int MB = 40;
  logic            clk = 1'b0, rst_n = 1'b0, sg = 1'b0, pin = 1'b0, cold = 1'b0, warm = 1'b0;
  logic [MB-1:0]   word = '0, mw;
  logic            sclk, mv, core_n, wr, be, por_n, srst_n, din;
  logic [3:0]      mult;
  bmi_state_t      st;
  int              mismatches = 0, samples_checked = 0;
  logic [2:0]      r_m[4] = '{3'h0, 3'h3, 3'h6, 3'h7};
  logic            r_b8[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic            r_pin[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic [3:0]      r_mx[4] = '{4'h2, 4'h5, 4'h8, 4'h8};
  logic            r_be[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  always #50 clk = ~clk;
  bmi_reset_boot #(.MODE_BITS(MB)) DUT (.clk_sys_i(clk), .rst_n_i(rst_n), .supply_good_i(sg),
    .power_on_reset_n_i(por_n), .sys_reset_n_i(srst_n), .boot_serial_in_i(din),
    .byte_order_sel_i(pin), .boot_serial_clk_o(sclk), .mode_word_o(mw), .mode_valid_o(mv),
    .core_reset_n_o(core_n), .warm_reset_o(wr), .big_endian_o(be), .pll_mult_o(mult),
    .state_o(st));
  bmi_board_model #(.MODE_BITS(MB)) u_board (.clk_sys_i(clk), .sg_i(sg), .sclk_i(sclk),
    .cold_i(cold), .warm_i(warm), .word_i(word), .por_n_o(por_n), .rst_n_o(srst_n),
    .data_o(din));
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // Supply raised just after a serial clock rise so the ROM starts at bit 0
  task automatic boot(input logic [MB-1:0] w, input logic p);
    int n;
    @(negedge clk);
    sg = 1'b0;
    pin = p;
    word = w;
    repeat (8) @(negedge clk);
    @(posedge sclk);
    repeat (2) @(negedge clk);
    sg = 1'b1;
    n = 0;
    while (st !== BMI_RUN && n < MB * 256 + 600) begin
      @(negedge clk);
      n++;
    end
    `CHK(st, BMI_RUN)
    repeat (2) @(negedge clk);
  endtask : boot
  task automatic pins(input logic c, input logic wm);
    @(negedge clk);
    cold = c;
    warm = wm;
    repeat (10) @(negedge clk);
  endtask : pins
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    close_out();
  end
  initial begin
    logic [MB-1:0] w;
    time           t0;
    repeat (4) @(negedge clk);
    `CHK({st, sclk, core_n, mv, mult}, {BMI_IDLE, 3'b000, 4'h2})
    rst_n = 1'b1;
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      w = 40'h82_0010_0001 | (MB'(r_m[i]) << 5) | (MB'(r_b8[i]) << 8);
      boot(w, r_pin[i]);
      `CHK(mw, w)
      `CHK(mult, r_mx[i])
      `CHK(be, r_be[i])
      `CHK({mv, core_n, wr}, 3'b110)
      $display("row %0d done", i);
    end
    @(posedge sclk);
    t0 = $time;
    @(negedge sclk);
    `CHK($time - t0, 64'd12800)
    @(posedge sclk);
    `CHK($time - t0, 64'd25600)
    $display("serial clock test done");
    pins(1'b0, 1'b1);
    `CHK({st, wr, core_n, mv}, {BMI_HOLD, 3'b101})
    `CHK(mw, w)
    pins(1'b0, 1'b0);
    `CHK({st, wr, core_n}, {BMI_RUN, 2'b01})
    pins(1'b1, 1'b0);
    `CHK({st, wr, core_n}, {BMI_HOLD, 2'b00})
    pins(1'b0, 1'b0);
    `CHK(st, BMI_RUN)
    $display("warm and cold test done");
    @(negedge clk);
    sg = 1'b0;
    repeat (10) @(negedge clk);
    `CHK({st, core_n, mv}, {BMI_IDLE, 2'b00})
    $display("supply loss test done");
    close_out();
  end
endmodule : bmi_reset_boot_tb_top
`default_nettype wire
